// *** rtl/sbpd_page_decode.sv ***
`timescale 1ns/10ps
// How it works
// - Decode pages FC00 and FD00, each driving its own active-low select.
// - Each select stays low one or one and a half microseconds per access.
// - ROM output enable is forced high while either select is low.
// - Slow-cycle request is high while either select is low.
// - Data buffer enable is low only while either select is low.
// - ROM disable, slow request and buffer enable share one decode term.
// - With the buffer enabled, data passes between host and expansion sides.
module sbpd_page_decode (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire sbpd_pkg::sbpd_req_s host_req,
    input  wire logic              rom_oe_n_in,
    input  wire logic              phase_1m,
    input  wire logic [7:0]        exp_data_in,
    output logic                   page_fc_n,
    output logic                   page_fd_n,
    output logic                   rom_oe_n,
    output logic                   slow_cycle_request,
    output logic                   buf_en_n,
    output logic [7:0]             exp_data_out,
    output logic                   exp_data_oe,
    output logic [7:0]             host_rdata
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic       phase_s1_reg;
    logic       phase_s2_reg;
    logic [7:0] exp_s1_reg;
    logic [7:0] exp_s2_reg;

    // Two stages on slow phase and expansion data
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_s1_reg <= 1'b0;
            phase_s2_reg <= 1'b0;
            exp_s1_reg   <= sbpd_pkg::DATA_RST;
            exp_s2_reg   <= sbpd_pkg::DATA_RST;
        end else begin
            phase_s1_reg <= phase_1m;
            phase_s2_reg <= phase_s1_reg;
            exp_s1_reg   <= exp_data_in;
            exp_s2_reg   <= exp_s1_reg;
        end
    end

    // ==========================================================
    // Decode and stretch
    // ==========================================================
    sbpd_pkg::sbpd_state_e state_reg;
    logic [9:0]            cnt_reg;
    logic                  fd_sel_reg;
    logic                  rnw_reg;
    logic                  hit_fc;
    logic                  hit_fd;
    logic                  accept;
    logic                  sel_next;
    logic                  fd_next;

    assign hit_fc   = host_req.addr[15:8] == sbpd_pkg::PAGE_FC_HI;
    assign hit_fd   = host_req.addr[15:8] == sbpd_pkg::PAGE_FD_HI;
    // Accesses during a stretch are ignored
    assign accept   = host_req.valid && (hit_fc || hit_fd) && (state_reg == sbpd_pkg::SBPD_IDLE);
    assign sel_next = accept || ((state_reg == sbpd_pkg::SBPD_BUSY) && (cnt_reg != 10'h000));
    assign fd_next  = accept ? hit_fd : fd_sel_reg;

    // Stretch state and remaining count
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg  <= sbpd_pkg::SBPD_IDLE;
            cnt_reg    <= 10'h000;
            fd_sel_reg <= 1'b0;
            rnw_reg    <= 1'b1;
        end else begin
            case (state_reg)
                sbpd_pkg::SBPD_IDLE: begin
                    if (accept) begin
                        state_reg  <= sbpd_pkg::SBPD_BUSY;
                        fd_sel_reg <= hit_fd;
                        rnw_reg    <= host_req.rnw;
                        cnt_reg    <= phase_s2_reg ? sbpd_pkg::LONG_CYC - 10'h001
                                                   : sbpd_pkg::SHORT_CYC - 10'h001;
                    end
                end
                sbpd_pkg::SBPD_BUSY: begin
                    if (cnt_reg == 10'h000) begin
                        state_reg <= sbpd_pkg::SBPD_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 10'h001;
                    end
                end
                default: begin
                    state_reg <= sbpd_pkg::SBPD_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Select and bus control outputs
    // ==========================================================
    logic page_fc_n_reg;
    logic page_fd_n_reg;
    logic rom_oe_n_reg;
    logic slow_req_reg;
    logic buf_en_n_reg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            page_fc_n_reg <= 1'b1;
            page_fd_n_reg <= 1'b1;
            rom_oe_n_reg  <= 1'b1;
            slow_req_reg  <= 1'b0;
            buf_en_n_reg  <= 1'b1;
        end else begin
            page_fc_n_reg <= !(sel_next && !fd_next);
            page_fd_n_reg <= !(sel_next && fd_next);
            rom_oe_n_reg  <= sel_next ? 1'b1 : rom_oe_n_in;
            slow_req_reg  <= sel_next;
            buf_en_n_reg  <= !sel_next;
        end
    end

    // ==========================================================
    // Data path
    // ==========================================================
    logic [7:0] exp_dout_reg;
    logic       exp_doe_reg;
    logic [7:0] host_rdata_reg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            exp_dout_reg   <= sbpd_pkg::DATA_RST;
            exp_doe_reg    <= 1'b0;
            host_rdata_reg <= sbpd_pkg::DATA_RST;
        end else begin
            if (accept && !host_req.rnw) begin
                exp_dout_reg <= host_req.wdata;
            end
            exp_doe_reg <= sel_next && (accept ? !host_req.rnw : !rnw_reg);
            if (state_reg == sbpd_pkg::SBPD_BUSY && rnw_reg) begin
                host_rdata_reg <= exp_s2_reg;
            end
        end
    end

    assign page_fc_n          = page_fc_n_reg;
    assign page_fd_n          = page_fd_n_reg;
    assign rom_oe_n           = rom_oe_n_reg;
    assign slow_cycle_request = slow_req_reg;
    assign buf_en_n           = buf_en_n_reg;
    assign exp_data_out       = exp_dout_reg;
    assign exp_data_oe        = exp_doe_reg;
    assign host_rdata         = host_rdata_reg;

    // ==========================================================
    // Checks
    // ==========================================================
    logic [9:0] low_len_reg;
    logic       any_sel;

    assign any_sel = !page_fc_n_reg || !page_fd_n_reg;

    // Length of the current low select
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            low_len_reg <= 10'h000;
        end else begin
            low_len_reg <= any_sel ? low_len_reg + 10'h001 : 10'h000;
        end
    end

    AST_DECODE_FC: assert property (
        @(posedge ref_clk) disable iff (reset)
        (accept && hit_fc) |=> (!page_fc_n && page_fd_n))
        else $error("first page select not asserted");

    AST_DECODE_FD: assert property (
        @(posedge ref_clk) disable iff (reset)
        (accept && hit_fd) |=> (!page_fd_n && page_fc_n))
        else $error("second page select not asserted");

    AST_STRETCH_LEN: assert property (
        @(posedge ref_clk) disable iff (reset)
        (any_sel && !sel_next) |->
            (low_len_reg + 10'h001 == sbpd_pkg::SHORT_CYC ||
             low_len_reg + 10'h001 == sbpd_pkg::LONG_CYC))
        else $error("select low time is neither short nor long");

    AST_SHORT_HOLD: assert property (
        @(posedge ref_clk) disable iff (reset)
        (accept && !phase_s2_reg) |=> any_sel [*8])
        else $error("select released early");

    AST_ROM_OFF: assert property (
        @(posedge ref_clk) disable iff (reset)
        any_sel |-> rom_oe_n)
        else $error("ROM enabled during page select");

    AST_SLOW_REQ: assert property (
        @(posedge ref_clk) disable iff (reset)
        any_sel |-> slow_cycle_request)
        else $error("slow request low during page select");

    AST_BUF_EN: assert property (
        @(posedge ref_clk) disable iff (reset)
        buf_en_n == !any_sel)
        else $error("buffer enable mismatch");

    AST_COMMON: assert property (
        @(posedge ref_clk) disable iff (reset)
        $changed(slow_cycle_request) |-> $changed(buf_en_n) && slow_cycle_request != buf_en_n)
        else $error("controls not changing together");

    AST_WRITE_PASS: assert property (
        @(posedge ref_clk) disable iff (reset)
        (accept && !host_req.rnw) |=>
            (exp_data_oe && !buf_en_n && exp_data_out == $past(host_req.wdata)))
        else $error("write data not driven");

    AST_OUTSIDE: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_reg == sbpd_pkg::SBPD_IDLE && !accept) |=>
            (page_fc_n && page_fd_n && !slow_cycle_request && buf_en_n && !exp_data_oe))
        else $error("bus active outside decoded pages");

    COV_SHORT: cover property (@(posedge ref_clk) disable iff (reset)
        accept && !phase_s2_reg);
    COV_LONG: cover property (@(posedge ref_clk) disable iff (reset)
        accept && phase_s2_reg);
    COV_READ: cover property (@(posedge ref_clk) disable iff (reset)
        accept && host_req.rnw && hit_fd);

endmodule : sbpd_page_decode

// *** rtl/sbpd_pkg.sv ***
package sbpd_pkg;

    // ==========================================================
    // Page decode
    // ==========================================================
    localparam logic [7:0] PAGE_FC_HI = 8'hfc; // Upper address byte of the first page
    localparam logic [7:0] PAGE_FD_HI = 8'hfd; // Upper address byte of the second page

    // ==========================================================
    // Select stretch timing
    // ==========================================================
    localparam int CLK_MHZ  = 250;
    localparam int SHORT_NS = 1000;            // Select aligned with slow phase
    localparam int LONG_NS  = 1500;            // Select that must wait half a slow cycle
    localparam logic [9:0] SHORT_CYC = 10'((SHORT_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] LONG_CYC  = 10'((LONG_NS * CLK_MHZ + 999) / 1000);

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] DATA_RST = 8'h00;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [0:0] {
        SBPD_IDLE,
        SBPD_BUSY
    } sbpd_state_e;

    typedef struct packed {
        logic        valid; // One-cycle access strobe
        logic        rnw;   // High for a read
        logic [15:0] addr;
        logic [7:0]  wdata;
    } sbpd_req_s;

endpackage : sbpd_pkg

// *** tb/sbpd_card_model.sv ***
`timescale 1ns/10ps
module sbpd_card_model (
    input  wire logic       ref_clk,
    input  wire logic       buf_en_n,
    input  wire logic       exp_data_oe,
    input  wire logic [7:0] exp_data_out,
    input  wire logic [7:0] rd_value,
    output logic            phase_1m,
    output logic [7:0]      exp_data_in
);
    logic [7:0] last_reg = 8'h00; // Known start so the idle wire never sits unknown

    // ====================
    // Slow bus phase
    // Free running 1 MHz phase, not tied to the fast clock edges
    initial begin
        phase_1m = 1'b0;
        forever #500 phase_1m = ~phase_1m;
    end

    // ====================
    // Expansion data wire
    // Host drives on writes, card answers while buffered, else the wire wanders
    always_comb begin
        if (exp_data_oe) begin
            exp_data_in = exp_data_out;
        end else if (!buf_en_n) begin
            exp_data_in = rd_value;
        end else begin
            exp_data_in = ~last_reg;
        end
    end

    // Last wire level, inverted above so a released bus never looks stable
    always @(posedge ref_clk) begin
        last_reg <= exp_data_in;
    end
endmodule : sbpd_card_model

// *** tb/slow_bus_page_decode_bench.sv ***
`timescale 1ns/10ps
module slow_bus_page_decode_bench;
    logic                ref_clk;
    logic                reset;
    sbpd_pkg::sbpd_req_s host_req;
    logic                rom_oe_n_in;
    logic                phase_1m;
    logic [7:0]          exp_data_in;
    logic                page_fc_n;
    logic                page_fd_n;
    logic                rom_oe_n;
    logic                slow_cycle_request;
    logic                buf_en_n;
    logic [7:0]          exp_data_out;
    logic                exp_data_oe;
    logic [7:0]          host_rdata;
    logic [7:0]          rd_value;
    int                  err_count;
    int                  n_compared;

    sbpd_page_decode dut_u (.ref_clk(ref_clk), .reset(reset), .host_req(host_req),
        .rom_oe_n_in(rom_oe_n_in), .phase_1m(phase_1m), .exp_data_in(exp_data_in),
        .page_fc_n(page_fc_n), .page_fd_n(page_fd_n), .rom_oe_n(rom_oe_n),
        .slow_cycle_request(slow_cycle_request), .buf_en_n(buf_en_n),
        .exp_data_out(exp_data_out), .exp_data_oe(exp_data_oe), .host_rdata(host_rdata));

    sbpd_card_model card_u (.ref_clk(ref_clk), .buf_en_n(buf_en_n),
        .exp_data_oe(exp_data_oe), .exp_data_out(exp_data_out), .rd_value(rd_value),
        .phase_1m(phase_1m), .exp_data_in(exp_data_in));

    // ====================
    // Clock and helpers
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask : step

    task automatic print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // Settle a few cycles into the wanted slow phase level
    task automatic wait_phase(input logic ph);
        int g;
        g = 0;
        while (phase_1m === ph && g < 300) begin
            step;
            g++;
        end
        while (phase_1m !== ph && g < 600) begin
            step;
            g++;
        end
        if (g >= 600) begin
            err_count++;
            $display("MISMATCH at %0t: phase wait ran out", $time);
            print_verdict;
        end
        repeat (8) step;
    endtask : wait_phase

    // One access: measure the stretch and watch every cycle of it
    task automatic run_access(input logic rnw, input logic [15:0] addr, input logic [7:0] wd,
                              input logic ph, input logic [9:0] len);
        logic       fd;
        logic [9:0] n;
        logic [9:0] bad;
        fd = addr[8];
        n = '0;
        bad = '0;
        wait_phase(ph);
        host_req = '{1'b1, rnw, addr, wd};
        step;
        while ((fd ? page_fd_n : page_fc_n) === 1'b0 && n < 10'd600) begin
            if (rom_oe_n !== 1'b1 || slow_cycle_request !== 1'b1 || buf_en_n !== 1'b0)
                bad++;
            if ((fd ? page_fc_n : page_fd_n) !== 1'b1 || exp_data_oe !== ~rnw
                || (!rnw && exp_data_out !== wd))
                bad++;
            if (rnw && n == 10'd100)
                check(10'(host_rdata), 10'(rd_value), "read data mid access");
            // Access to the other page while busy is dropped
            host_req = '{n == 10'd30, 1'b0, addr ^ 16'h0100, 8'hff};
            step;
            n++;
        end
        check(n, len, "select length");
        check(bad, 10'd0, "bad control cycles");
        check(10'({slow_cycle_request, buf_en_n, exp_data_oe, rom_oe_n}),
              10'({3'b010, rom_oe_n_in}), "release");
        if (rnw)
            check(10'(host_rdata), 10'(rd_value), "read data held");
    endtask : run_access

    // ====================
    // Scenarios
    task automatic test_outside;
        logic [15:0] addrs [4] = '{16'hfbff, 16'hfe00, 16'h00fc, 16'h7c00};
        for (int i = 0; i < 4; i++) begin
            rom_oe_n_in = i[0];
            host_req = '{1'b1, i[1], addrs[i], 8'h77};
            step;
            host_req.valid = 1'b0;
            repeat (3) step;
            check(10'({page_fc_n, page_fd_n, slow_cycle_request, buf_en_n, exp_data_oe,
                       rom_oe_n}),
                  10'({5'b11010, rom_oe_n_in}), "outside access");
        end
        rom_oe_n_in = 1'b0;
        step;
    endtask : test_outside

    task automatic test_write_fc;
        run_access(1'b0, 16'hfc10, 8'h5a, 1'b0, sbpd_pkg::SHORT_CYC);
        run_access(1'b0, 16'hfcff, 8'ha5, 1'b1, sbpd_pkg::LONG_CYC);
    endtask : test_write_fc

    task automatic test_read_fd;
        rd_value = 8'ha5;
        run_access(1'b1, 16'hfd00, 8'h00, 1'b1, sbpd_pkg::LONG_CYC);
        rd_value = 8'h3c;
        run_access(1'b1, 16'hfdff, 8'h00, 1'b0, sbpd_pkg::SHORT_CYC);
    endtask : test_read_fd

    // ====================
    // Main sequence
    initial begin
        err_count = 0;
        n_compared = 0;
        reset = 1'b1;
        host_req = '0;
        rom_oe_n_in = 1'b0;
        rd_value = 8'h00;
        repeat (5) step;
        reset = 1'b0;
        step;
        test_outside;
        test_write_fc;
        test_read_fd;
        print_verdict;
    end
endmodule : slow_bus_page_decode_bench
